// [hdl/ast_regs.svh]
// Constants for the asynchronous serial transmitter: levels, counts and sizes.
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// Line levels of the non-return-to-zero link.
`define AST_MARK 1'b1
`define AST_SPACE 1'b0

// Character layout: data bits per frame and stored word width.
`define AST_BITS_8 4'h8
`define AST_BITS_9 4'h9
`define AST_WORD_W 9
`define AST_BYTE_W 8

// Baud prescale: clocks per divider step minus one, per speed selection.
`define AST_PRE_W 6
`define AST_PRE_HIGH 6'h0f
`define AST_PRE_LOW 6'h3f

// Depth of the write queue in front of the holding buffer.
`define AST_FIFO_DEPTH 4

`endif

// [hdl/ast_pkg.sv]
// Types shared by the asynchronous serial transmitter modules.
package ast_pkg;

    typedef enum logic [3:0] {
        AST_IDLE  = 4'h1,
        AST_START = 4'h2,
        AST_DATA  = 4'h4,
        AST_STOP  = 4'h8
    } ast_state_e;

    typedef logic [8:0] ast_word_t;

endpackage : ast_pkg

// [hdl/ast_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ast_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push_w;
    logic pop_w;

    assign push_w = in_valid & in_ready;
    assign pop_w = out_valid & out_ready;
    assign out_data = mem_r[rd_idx_r];

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (push_w && !pop_w)
            cnt_nxt = cnt_r + CW'(1);
        else if (pop_w && !push_w)
            cnt_nxt = cnt_r - CW'(1);
    end

    // Full and empty are kept as flops so both ready and valid are clean.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != FULL_CNT);
            out_valid <= (cnt_nxt != '0);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
        end
        else
        begin
            if (push_w)
                wr_idx_r <= (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + AW'(1);
            if (pop_w)
                rd_idx_r <= (rd_idx_r == LAST_IDX) ? '0 : rd_idx_r + AW'(1);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_entry
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    mem_r[gi] <= '0;
                else if (push_w && wr_idx_r == AW'(gi))
                    mem_r[gi] <= in_data;
            end
        end
    endgenerate

endmodule : ast_fifo

// [hdl/ast_baud.sv]
// Bit-period generator: prescaler followed by an 8-bit reloading divider.
`timescale 1ns/1ps
`include "ast_regs.svh"
module ast_baud #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic restart,
    input wire logic [DIV_W-1:0] divisor,
    input wire logic high_speed,
    // Bit boundary pulse
    output logic bit_tick
);
    logic [`AST_PRE_W-1:0] pre_r;
    logic [`AST_PRE_W-1:0] pre_max_w;
    logic [DIV_W-1:0] div_r;

    assign pre_max_w = high_speed ? `AST_PRE_HIGH : `AST_PRE_LOW;
    // The tick is combinational so the first bit after a restart is exact.
    // It must not look at restart, because restart is made from the tick.
    // A tick that meets a restart is harmless: the load wins in the shifter.
    assign bit_tick = pre_r == '0 && div_r == '0;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_r <= '0;
            div_r <= '0;
        end
        else if (restart)
        begin
            pre_r <= pre_max_w;
            div_r <= divisor;
        end
        else if (pre_r == '0)
        begin
            pre_r <= pre_max_w;
            div_r <= (div_r == '0) ? divisor : div_r - DIV_W'(1);
        end
        else
            pre_r <= pre_r - `AST_PRE_W'(1);
    end

endmodule : ast_baud

// [hdl/ast_tx.sv]
// Asynchronous serial transmitter: queue, holding buffer, shifter and pins.
//
// Operation
// RQ1: Line idles at mark between frames.
// RQ2: Frame is start, 8/9 data, stop.
// RQ3: Each bit lasts one divider-made baud period.
// RQ4: Data bits leave least significant first.
// RQ5: Format and rate shared with receiver.
// RQ6: No parity generated; host uses ninth bit.
// RQ7: Active only when enabled, asynchronous, port on.
// RQ8: Port enable forces pin directions, mutes latch.
// RQ9: Buffer write starts sending, loads empty shifter.
// RQ10: Queued character loads right after stop bit.
// RQ11: Start bit begins right after shifter load.
// RQ12: Empty flag set whenever holding buffer free.
// RQ13: Empty flag sets when transmit enable sets.
// RQ14: Empty flag valid two cycles after write.
// RQ15: Empty flag is read-only.
// RQ16: Flag ignores enable; request needs three enables.
// RQ17: Shifter-empty bit clears on load, sets after.
// RQ18: Nine-bit mode sends ninth bit last.
// RQ19: Host writes ninth bit before data byte.
// RQ20: Set ninth bit marks an address byte.
// RQ21: Host follows recommended setup order.
// RQ22: Host enables interrupt only while data remains.
// RQ23: Bit counter reloads divider every boundary.
`timescale 1ns/1ps
`include "ast_regs.svh"
module ast_tx
    import ast_pkg::*;
#(
    parameter int FIFO_DEPTH = `AST_FIFO_DEPTH,
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration bits
    input wire logic tx_enable_bit,
    input wire logic clocked_mode_select,
    input wire logic serial_port_enable,
    input wire logic nine_bit_tx_select,
    input wire logic tx_ninth_bit,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic baud_high_speed,
    // Interrupt enables
    input wire logic tx_interrupt_enable,
    input wire logic peripheral_irq_gate,
    input wire logic global_irq_enable,
    // Host write into the holding path
    input wire logic tx_wr_valid,
    input wire logic [`AST_BYTE_W-1:0] tx_wr_data,
    output logic tx_wr_ready,
    // Status
    output logic tx_buffer_empty_flag,
    output logic shift_register_empty,
    output logic tx_irq_req,
    // General port latch and direction for the two shared pins
    input wire logic tx_clock_pin_latch,
    input wire logic tx_clock_pin_dir_in,
    input wire logic rx_data_pin_latch,
    input wire logic rx_data_pin_dir_in,
    // Pins
    output logic tx_clock_pin_out,
    output logic tx_clock_pin_oe,
    input wire logic rx_data_pin_in,
    output logic rx_data_pin_out,
    output logic rx_data_pin_oe,
    output logic rx_data_pin_level
);
    import ast_pkg::*;

    ast_state_e state_r;
    ast_state_e state_nxt;
    ast_word_t hold_r;
    ast_word_t shift_r;
    ast_word_t fifo_in_w;
    ast_word_t fifo_out_w;
    logic hold_full_r;
    logic [3:0] bits_left_r;
    logic fifo_valid_w;
    logic fifo_ready_w;
    logic fifo_pop_w;
    logic active_w;
    logic bit_tick_w;
    logic stop_done_w;
    logic load_w;
    logic flag_nxt;
    logic line_nxt;
    logic rx_meta_r;
    logic rx_sync_r;

    // Transmission runs only in asynchronous mode with both enables set.
    assign active_w = tx_enable_bit & ~clocked_mode_select
                      & serial_port_enable;  // [RQ7]

    // The ninth bit is taken with the byte, so it must be set up first.
    assign fifo_in_w = {tx_ninth_bit & nine_bit_tx_select,
                        tx_wr_data};  // [RQ18] [RQ19] [RQ20]

    // Host writes queue here; the ready back-pressures the writer.
    ast_fifo #(
        .WIDTH(`AST_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(tx_wr_valid),
        .in_data(fifo_in_w),
        .in_ready(fifo_ready_w),
        .out_valid(fifo_valid_w),
        .out_ready(~hold_full_r),
        .out_data(fifo_out_w)
    );

    assign tx_wr_ready = fifo_ready_w;
    assign fifo_pop_w = fifo_valid_w & ~hold_full_r;

    // Rate is one shared setting; the receiver reads the same divisor.
    ast_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .clk(clk),
        .rst_b(rst_b),
        .restart(load_w),
        .divisor(baud_divisor),
        .high_speed(baud_high_speed),
        .bit_tick(bit_tick_w)
    );  // [RQ3] [RQ5] [RQ23]

    assign stop_done_w = (state_r == AST_STOP) && bit_tick_w;

    // A held character enters the shifter when it is idle or at the end
    // of the stop bit, in the same clock, so no instruction cycle is lost.
    assign load_w = active_w && hold_full_r
                    && (state_r == AST_IDLE || stop_done_w);  // [RQ9] [RQ10]

    // Holding buffer: one character deep, refilled from the queue.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_r <= '0;
            hold_full_r <= 1'b0;
        end
        else if (fifo_pop_w)
        begin
            hold_r <= fifo_out_w;
            hold_full_r <= 1'b1;
        end
        else if (load_w)
            hold_full_r <= 1'b0;
    end

    // Frame sequencing.
    always_comb
    begin
        state_nxt = state_r;
        if (!active_w)
            state_nxt = AST_IDLE;
        else if (load_w)
            state_nxt = AST_START;  // [RQ11]
        else
        begin
            case (state_r)
                AST_IDLE:
                    state_nxt = AST_IDLE;
                AST_START:
                    if (bit_tick_w)
                        state_nxt = AST_DATA;
                AST_DATA:
                    if (bit_tick_w && bits_left_r == 4'h1)
                        state_nxt = AST_STOP;
                AST_STOP:
                    if (bit_tick_w)
                        state_nxt = AST_IDLE;
                default:
                    state_nxt = AST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= AST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Shifter: bit 0 is on the line, shifts right once per bit period.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_r <= '0;
            bits_left_r <= 4'h0;
        end
        else if (load_w)
        begin
            shift_r <= hold_r;
            bits_left_r <= nine_bit_tx_select ? `AST_BITS_9
                                              : `AST_BITS_8;  // [RQ18]
        end
        else if (state_r == AST_DATA && bit_tick_w)
        begin
            shift_r <= {1'b0, shift_r[8:1]};  // [RQ4]
            bits_left_r <= bits_left_r - 4'h1;
        end
    end

    // Line level follows the next state so a frame starts on the load edge.
    // No parity stage exists; the ninth bit is passed through untouched.
    always_comb
    begin
        case (state_nxt)
            AST_START:
                line_nxt = `AST_SPACE;  // [RQ2]
            AST_DATA:
                line_nxt = (state_r == AST_DATA && bit_tick_w)
                           ? shift_r[1] : shift_r[0];  // [RQ2] [RQ6]
            AST_STOP:
                line_nxt = `AST_MARK;  // [RQ2]
            default:
                line_nxt = `AST_MARK;  // [RQ1]
        endcase
    end

    // The flag is pure status: no host path writes it.
    assign flag_nxt = tx_enable_bit && !hold_full_r && !fifo_valid_w
                      && !fifo_pop_w;  // [RQ12] [RQ13] [RQ15]

    // Status is registered behind the queue's valid flop, so it settles two
    // clocks after a write, within the two cycles the host must wait before polling.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_buffer_empty_flag <= 1'b0;
            tx_irq_req <= 1'b0;
        end
        else
        begin
            tx_buffer_empty_flag <= flag_nxt;  // [RQ14]
            tx_irq_req <= flag_nxt & tx_interrupt_enable
                          & peripheral_irq_gate
                          & global_irq_enable;  // [RQ16]
        end
    end

    // Shifter-empty has no interrupt path; the host polls it.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            shift_register_empty <= 1'b1;
        else
            shift_register_empty <= (state_nxt == AST_IDLE);  // [RQ17]
    end

    // Pin takeover: with the port enabled the transmit pin is always an
    // output and the receive pin an input, whatever the direction bits say.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_clock_pin_out <= `AST_MARK;
            tx_clock_pin_oe <= 1'b0;
            rx_data_pin_out <= 1'b0;
            rx_data_pin_oe <= 1'b0;
        end
        else if (serial_port_enable)
        begin
            tx_clock_pin_out <= line_nxt;  // [RQ1]
            tx_clock_pin_oe <= 1'b1;  // [RQ8]
            rx_data_pin_out <= 1'b0;
            rx_data_pin_oe <= 1'b0;  // [RQ8]
        end
        else
        begin
            tx_clock_pin_out <= tx_clock_pin_latch;
            tx_clock_pin_oe <= ~tx_clock_pin_dir_in;
            rx_data_pin_out <= rx_data_pin_latch;
            rx_data_pin_oe <= ~rx_data_pin_dir_in;
        end
    end

    // The receive pin stays readable through a three-stage synchroniser.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_data_pin_level <= 1'b1;
        end
        else
        begin
            rx_meta_r <= rx_data_pin_in;
            rx_sync_r <= rx_meta_r;
            rx_data_pin_level <= rx_sync_r;  // [RQ8]
        end
    end

endmodule : ast_tx

// [tb/ast_tx_asserts.sv]
// Port-level assertions for the asynchronous serial transmitter.
`timescale 1ns/1ps
module ast_tx_chk #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controls
    input wire logic tx_enable_bit,
    input wire logic clocked_mode_select,
    input wire logic serial_port_enable,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic baud_high_speed,
    input wire logic tx_interrupt_enable,
    input wire logic peripheral_irq_gate,
    input wire logic global_irq_enable,
    // Outputs
    input wire logic tx_buffer_empty_flag,
    input wire logic shift_register_empty,
    input wire logic tx_irq_req,
    input wire logic tx_clock_pin_out,
    input wire logic tx_clock_pin_oe,
    input wire logic rx_data_pin_oe
);
    logic en3;
    logic run_en;
    logic last_r;
    int run_r;
    int per;

    assign en3 = tx_interrupt_enable & peripheral_irq_gate & global_irq_enable;
    assign run_en = tx_enable_bit & ~clocked_mode_select & serial_port_enable;
    assign per = (int'(baud_divisor) + 1) * (baud_high_speed ? 16 : 64);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            last_r <= 1'b1;
        else
            last_r <= tx_clock_pin_out;
    end

    // Clocks the current line level has stood; restarts on every change and is held at one while the shifter is empty.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            run_r <= 1;
        else if (shift_register_empty || last_r != tx_clock_pin_out)
            run_r <= 1;
        else
            run_r <= run_r + 1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_bit_period: assert property (
        !shift_register_empty && !$past(shift_register_empty) &&
        last_r != tx_clock_pin_out |-> run_r % per == 0)
        else $error("line level changed off a bit boundary");
    a_idle_mark: assert property (
        serial_port_enable && $past(serial_port_enable) &&
        shift_register_empty && $past(shift_register_empty)
        |-> tx_clock_pin_out)
        else $error("line not at mark while idle");
    a_start_space: assert property (
        $fell(shift_register_empty) |-> !tx_clock_pin_out)
        else $error("frame did not open with a space");
    a_irq_gate: assert property (
        tx_irq_req |-> $past(en3) &&
        (tx_buffer_empty_flag || $past(tx_buffer_empty_flag)))
        else $error("request without flag and all enables");
    a_irq_raise: assert property (
        en3 && $past(en3) && tx_buffer_empty_flag &&
        $past(tx_buffer_empty_flag) |-> tx_irq_req)
        else $error("request missing with flag and enables");
    a_flag_needs_en: assert property (
        !$past(tx_enable_bit) |-> !tx_buffer_empty_flag)
        else $error("empty flag set while transmit disabled");
    a_flag_on_enable: assert property (
        $rose(tx_enable_bit) && shift_register_empty
        |-> ##[1:2] tx_buffer_empty_flag)
        else $error("empty flag not set after enable");
    a_pins_taken: assert property (
        serial_port_enable |=> tx_clock_pin_oe && !rx_data_pin_oe)
        else $error("port enable did not take the pins over");
    a_off_idle: assert property (
        !run_en |-> ##[1:2] shift_register_empty)
        else $error("shifter busy while transmission disabled");

    c_frame: cover property ($fell(shift_register_empty));
    c_irq: cover property ($rose(tx_irq_req));
    c_queued: cover property ($fell(tx_buffer_empty_flag));
endmodule : ast_tx_chk

bind ast_tx ast_tx_chk #(.DIV_W(DIV_W)) ast_tx_chk_inst (
    .clk, .rst_b, .tx_enable_bit, .clocked_mode_select, .serial_port_enable,
    .baud_divisor, .baud_high_speed, .tx_interrupt_enable,
    .peripheral_irq_gate, .global_irq_enable, .tx_buffer_empty_flag,
    .shift_register_empty, .tx_irq_req, .tx_clock_pin_out, .tx_clock_pin_oe,
    .rx_data_pin_oe
);

// [tb/ast_rx_model.sv]
// Remote line receiver model: recovers characters from the serial line.
`timescale 1ns/1ps
module ast_rx_model (
    // Clock
    input wire logic clk,
    // Line and shared format
    input wire logic line,
    input wire logic nine,
    input wire logic [31:0] period,
    // Recovered character
    output logic got,
    output logic [8:0] data,
    output logic frame_ok,
    output logic is_addr
);
    initial
    begin
        got = 1'b0;
        data = 9'h000;
        frame_ok = 1'b0;
        is_addr = 1'b0;
        forever
        begin
            @(negedge line);
            // Mid-bit sampling at the sender's own rate and format.
            repeat (period / 2) @(posedge clk);
            if (line == 1'b0)
            begin
                data = 9'h000;
                for (int i = 0; i < (nine ? 9 : 8); i++)
                begin
                    repeat (period) @(posedge clk);
                    data[i] = line;
                end
                repeat (period) @(posedge clk);
                frame_ok = line;
                is_addr = nine & data[8];
                got = 1'b1;
                @(posedge clk);
                got = 1'b0;
            end
        end
    end
endmodule : ast_rx_model

// [tb/ast_tx_test.sv]
// Self-checking bench: drives the transmitter, checks line and status.
`timescale 1ns/1ps
module ast_tx_test;
    logic clk = 1'b0, rst_b = 1'b0, tx_enable_bit = 1'b0;
    logic clocked_mode_select = 1'b0, serial_port_enable = 1'b0;
    logic nine_bit_tx_select = 1'b0, tx_ninth_bit = 1'b0;
    logic [7:0] baud_divisor = 8'h00, tx_wr_data = 8'h00;
    logic baud_high_speed = 1'b1, tx_interrupt_enable = 1'b0;
    logic peripheral_irq_gate = 1'b0, global_irq_enable = 1'b0;
    logic tx_wr_valid = 1'b0, tx_clock_pin_latch = 1'b0;
    logic tx_clock_pin_dir_in = 1'b1, rx_data_pin_latch = 1'b0;
    logic rx_data_pin_dir_in = 1'b1, rx_data_pin_in = 1'b1;
    logic tx_wr_ready, tx_buffer_empty_flag, shift_register_empty;
    logic tx_irq_req, tx_clock_pin_out, tx_clock_pin_oe;
    logic rx_data_pin_out, rx_data_pin_oe, rx_data_pin_level;
    logic got, frame_ok, is_addr;
    logic [8:0] got_data;
    logic [8:0] exp_q[$];
    int fails = 0, cmp_count = 0, per = 16, flen = 160;
    time last_t = 0;
    // The receiver listens only while the port owns the pin.
    wire rx_line = serial_port_enable & tx_clock_pin_oe ? tx_clock_pin_out
                                                         : 1'b1;

    ast_tx ast_tx_inst (.clk, .rst_b, .tx_enable_bit, .clocked_mode_select,
        .serial_port_enable, .nine_bit_tx_select, .tx_ninth_bit,
        .baud_divisor, .baud_high_speed, .tx_interrupt_enable,
        .peripheral_irq_gate, .global_irq_enable, .tx_wr_valid, .tx_wr_data,
        .tx_wr_ready, .tx_buffer_empty_flag, .shift_register_empty,
        .tx_irq_req, .tx_clock_pin_latch, .tx_clock_pin_dir_in,
        .rx_data_pin_latch, .rx_data_pin_dir_in, .tx_clock_pin_out,
        .tx_clock_pin_oe, .rx_data_pin_in, .rx_data_pin_out, .rx_data_pin_oe,
        .rx_data_pin_level);
    ast_rx_model ast_rx_model_inst (.clk, .line(rx_line),
        .nine(nine_bit_tx_select), .period(per), .got, .data(got_data),
        .frame_ok, .is_addr);

    always #12.5 clk = ~clk;

    task automatic summarize;
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic give_up;
        fails++;
        summarize();
    endtask : give_up

    task automatic chk_b(input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_b

    task automatic chk_w(input logic [8:0] e, input logic [8:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_w

    task automatic chk_t(input int e, input int g);
        cmp_count++;
        if (g != e)
        begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_t

    // Leaves the write request up so back-to-back writes need no gap.
    task automatic put(input logic [8:0] w);
        int n;
        n = 0;
        tx_ninth_bit = w[8];
        tx_wr_data = w[7:0];
        tx_wr_valid = 1'b1;
        while (tx_wr_ready !== 1'b1)
        begin
            n++;
            if (n > 5000)
                give_up();
            @(negedge clk);
        end
        @(negedge clk);
        exp_q.push_back(nine_bit_tx_select ? w : {1'b0, w[7:0]});
    endtask : put

    task automatic wait_idle;
        int n;
        n = 0;
        while (exp_q.size() != 0 || shift_register_empty !== 1'b1)
        begin
            n++;
            if (n > 40000)
                give_up();
            @(negedge clk);
        end
    endtask : wait_idle

    always @(posedge got)
    begin
        chk_b(1'b1, frame_ok);
        chk_b(1'b1, exp_q.size() > 0);
        if (exp_q.size() > 0)
        begin
            chk_b(nine_bit_tx_select & exp_q[0][8], is_addr);
            chk_w(exp_q.pop_front(), got_data);
        end
        if (last_t != 0)
            chk_t(flen, int'(($time - last_t) / 25));
        last_t = $time;
    end

    initial
    begin
        void'($urandom(67));
        repeat (5) @(negedge clk);
        chk_b(1'b1, tx_wr_ready);
        chk_b(1'b0, tx_buffer_empty_flag);
        chk_b(1'b1, shift_register_empty);
        chk_b(1'b0, tx_irq_req);
        @(negedge clk);
        rst_b = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            {tx_clock_pin_latch, tx_clock_pin_dir_in, rx_data_pin_latch,
                rx_data_pin_dir_in, rx_data_pin_in} = 5'($urandom);
            serial_port_enable = k[2];
            repeat (4) @(negedge clk);
            chk_b(serial_port_enable | ~tx_clock_pin_dir_in,
                tx_clock_pin_oe);
            chk_b(~serial_port_enable & ~rx_data_pin_dir_in,
                rx_data_pin_oe);
            chk_b(serial_port_enable | tx_clock_pin_latch,
                tx_clock_pin_out);
            chk_b(~serial_port_enable & rx_data_pin_latch,
                rx_data_pin_out);
            chk_b(rx_data_pin_in, rx_data_pin_level);
        end
        chk_b(1'b0, tx_buffer_empty_flag);
        tx_enable_bit = 1'b1;
        repeat (2) @(negedge clk);
        chk_b(1'b1, tx_buffer_empty_flag);
        for (int k = 0; k < 8; k++)
        begin
            {tx_interrupt_enable, peripheral_irq_gate, global_irq_enable} = 3'(k);
            repeat (2) @(negedge clk);
            chk_b(k == 7, tx_irq_req);
        end
        clocked_mode_select = 1'b1;
        put(9'h0a5);
        tx_wr_valid = 1'b0;
        repeat (3 * per) @(negedge clk);
        chk_b(1'b1, shift_register_empty);
        chk_b(1'b1, tx_clock_pin_out);
        clocked_mode_select = 1'b0;
        wait_idle();
        for (int m = 0; m < 4; m++)
        begin
            nine_bit_tx_select = m[0];
            baud_high_speed = ~m[1];
            baud_divisor = m[1] ? 8'h00 : 8'($urandom_range(0, 2));
            per = (int'(baud_divisor) + 1) * (baud_high_speed ? 16 : 64);
            flen = (m[0] ? 11 : 10) * per;
            tx_interrupt_enable = 1'b1;
            last_t = 0;
            put(9'($urandom));
            tx_wr_valid = 1'b0;
            for (int n = 0; n < 6 && shift_register_empty === 1'b1; n++)
                @(negedge clk);
            chk_b(1'b0, shift_register_empty);
            chk_b(1'b0, tx_clock_pin_out);
            for (int n = 0; n < 6; n++)
                put(9'($urandom));
            tx_interrupt_enable = 1'b0;
            tx_wr_valid = 1'b0;
            repeat (2) @(negedge clk);
            chk_b(1'b0, tx_buffer_empty_flag);
            chk_b(1'b0, tx_wr_ready);
            chk_b(1'b0, tx_irq_req);
            wait_idle();
            chk_b(1'b1, tx_buffer_empty_flag);
            chk_b(1'b1, tx_wr_ready);
        end
        summarize();
    end
endmodule : ast_tx_test
